// ==== rtl/reference_select_dpll_control.v ====
// control core of the main loop: input monitor, priority select,
// free-run / locked / holdover machine, holdover averaging, frame sync
// assumes all pins synchronous to ref_clk and inputs pre-scaled so
// that each reference edge is visible at the 250 MHz sample rate
//
// Contract
// - state machine changes state without software
// - leave free-run once any input valid
// - average loop frequency over 1 s
// - quick loss detection enters holdover
// - holdover switches to another valid input
// - revertive or nonrevertive reference choice
// - all inputs lost: stay in holdover
// - monitor five inputs: activity and frequency
// - pick highest-priority valid input
// - divide selected reference to lower rate
// - two missing cycles disqualify selected input
// - master rate is oscillator times 16
// - lock at 8 kHz to multiples
// - bandwidth 18 to 400 Hz, acquire/lock
// - damping choice of five values
// - three phase detector modes
// - phase build-out on switch, under 5 ns
// - phase offset to 200 ns, 6 ps
// - monitor loop: frequency or phase, 70 Hz
// - frame sync polarity, width, discipline
// - write protect blocks configuration writes
`include "ref_select_map.vh"
`timescale 1ns/1ns
`default_nettype none
module reference_select_dpll_control #(
    parameter AVG_CYCLES = `AVG_CYCLES
) (
    input wire ref_clk,
    input wire rst_n,
    input wire local_oscillator_input,
    input wire [4:0] ref_in,
    input wire sync_in,
    input wire cfg_load,
    input wire write_protect,
    input wire [14:0] prio_table_in,
    input wire revertive_in,
    input wire [7:0] div_ratio_in,
    input wire [15:0] period_lo_in,
    input wire [15:0] period_hi_in,
    input wire [8:0] bw_acq_in,
    input wire [8:0] bw_lock_in,
    input wire [2:0] damping_in,
    input wire [1:0] pd_mode_in,
    input wire [16:0] phase_offset_in,
    input wire [2:0] mon_sel_a_in,
    input wire [2:0] mon_sel_b_in,
    input wire mon_phase_mode_in,
    input wire [8:0] mon_bw_in,
    input wire fsync_pol_in,
    input wire [7:0] fsync_width_in,
    input wire [1:0] sync_mode_in,
    output reg [2:0] loop_state_reg,
    output reg [2:0] sel_ref_reg,
    output reg [4:0] ref_valid_reg,
    output reg loop_tick_reg,
    output reg [15:0] loop_period_reg,
    output reg [15:0] holdover_reg,
    output reg [8:0] loop_bw_reg,
    output reg [2:0] damping_reg,
    output reg [1:0] pd_mode_reg,
    output reg [13:0] slip_count_reg,
    output reg [23:0] phase_adjust_reg,
    output reg pbo_active_reg,
    output reg [15:0] mon_result_reg,
    output reg [8:0] mon_bw_reg,
    output reg osc_ok_reg,
    output reg fsync_out_reg,
    output reg mfsync_out_reg
);
    // interval counter is 28 bits, so the top bits are cut on purpose
    localparam [31:0] AVG_FULL = AVG_CYCLES - 1;
    localparam [27:0] AVG_LAST = AVG_FULL[27:0];
    localparam [31:0] PBO_FULL = `PBO_CYCLES;

    // configuration shadow, loaded only while unprotected
    reg [14:0] prio_q;
    reg revertive_q;
    reg [7:0] div_q;
    reg [15:0] lo_q;
    reg [15:0] hi_q;
    reg [8:0] bw_acq_q;
    reg [8:0] bw_lock_q;
    reg [16:0] offset_q;
    reg [2:0] mon_a_q;
    reg [2:0] mon_b_q;
    reg mon_phase_q;
    reg fsync_pol_q;
    reg [7:0] fsync_width_q;
    reg [1:0] sync_mode_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_q <= 15'h4321;
            revertive_q <= 1'b0;
            div_q <= 8'h00;
            lo_q <= 16'h0001;
            hi_q <= 16'hffff;
            bw_acq_q <= `BW_MAX;
            bw_lock_q <= `BW_MIN;
            damping_reg <= 3'h0;
            pd_mode_reg <= `PD_PFD;
            offset_q <= 17'h00000;
            mon_a_q <= 3'h0;
            mon_b_q <= 3'h1;
            mon_phase_q <= 1'b0;
            mon_bw_reg <= `MON_BW_MAX;
            fsync_pol_q <= 1'b0;
            fsync_width_q <= 8'h01;
            sync_mode_q <= `SYNC_NONE;
        end else if (cfg_load && !write_protect) begin
            prio_q <= prio_table_in;
            revertive_q <= revertive_in;
            div_q <= div_ratio_in;
            lo_q <= period_lo_in;
            hi_q <= period_hi_in;
            bw_acq_q <= (bw_acq_in < `BW_MIN) ? `BW_MIN :
                (bw_acq_in > `BW_MAX) ? `BW_MAX : bw_acq_in;
            bw_lock_q <= (bw_lock_in < `BW_MIN) ? `BW_MIN :
                (bw_lock_in > `BW_MAX) ? `BW_MAX : bw_lock_in;
            // unknown codes fall back to the lowest damping
            damping_reg <= (damping_in > `DAMP_MAX) ? 3'h0 : damping_in;
            pd_mode_reg <= (pd_mode_in > `PD_MULTI) ? `PD_PFD : pd_mode_in;
            offset_q <= phase_offset_in;
            mon_a_q <= mon_sel_a_in;
            mon_b_q <= mon_sel_b_in;
            mon_phase_q <= mon_phase_mode_in;
            mon_bw_reg <= (mon_bw_in > `MON_BW_MAX) ? `MON_BW_MAX :
                mon_bw_in;
            fsync_pol_q <= fsync_pol_in;
            fsync_width_q <= fsync_width_in;
            sync_mode_q <= sync_mode_in;
        end
    end

    // per-input activity and period monitors
    reg [4:0] ref_prev;
    reg [4:0] ref_edge;
    reg [15:0] gap_cnt [0:4];
    reg [15:0] period [0:4];
    integer i;
    integer j;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_prev <= 5'h00;
            ref_valid_reg <= 5'h00;
            for (i = 0; i < `NUM_IN; i = i + 1) begin
                gap_cnt[i] <= 16'h0000;
                period[i] <= 16'h0000;
            end
        end else begin
            ref_prev <= ref_in;
            for (i = 0; i < `NUM_IN; i = i + 1) begin
                if (ref_edge[i]) begin
                    // requalify only on a fresh in-range period
                    period[i] <= gap_cnt[i];
                    ref_valid_reg[i] <= (gap_cnt[i] >= lo_q) &&
                        (gap_cnt[i] <= hi_q);
                    gap_cnt[i] <= 16'h0001;
                end else begin
                    if (gap_cnt[i] != 16'hffff)
                        gap_cnt[i] <= gap_cnt[i] + 16'h0001;
                    if (gap_cnt[i] > hi_q)
                        ref_valid_reg[i] <= 1'b0;
                end
            end
        end
    end

    // priority choice: lowest nonzero code wins, zero disables
    reg [2:0] best;
    reg [2:0] best_prio;
    reg any_valid;
    always @* begin
        ref_edge = ref_in & ~ref_prev;
        best = 3'h0;
        best_prio = 3'h7;
        any_valid = 1'b0;
        for (j = 0; j < `NUM_IN; j = j + 1) begin
            if (ref_valid_reg[j] && prio_q[3*j +: 3] != 3'h0 &&
                (!any_valid || prio_q[3*j +: 3] < best_prio)) begin
                best = j[2:0];
                best_prio = prio_q[3*j +: 3];
                any_valid = 1'b1;
            end
        end
    end

    // fast loss: two expected cycles missing on the selected input
    wire [15:0] sel_gap = gap_cnt[sel_ref_reg];
    wire [16:0] sel_two = {period[sel_ref_reg], 1'b0};
    wire fast_loss = ({1'b0, sel_gap} > sel_two);
    wire sel_lost = fast_loss || !ref_valid_reg[sel_ref_reg];
    wire sel_edge = ref_edge[sel_ref_reg];

    // main loop state machine
    reg switch_now;
    reg [2:0] state_next;
    always @* begin
        state_next = loop_state_reg;
        switch_now = 1'b0;
        case (loop_state_reg)
            `ST_FREERUN: begin
                if (any_valid) begin
                    state_next = `ST_LOCKED;
                    switch_now = 1'b1;
                end
            end
            `ST_LOCKED: begin
                if (sel_lost) begin
                    state_next = `ST_HOLDOVER;
                end else if (revertive_q && any_valid &&
                    best != sel_ref_reg) begin
                    switch_now = 1'b1;
                end
            end
            `ST_HOLDOVER: begin
                // with nothing valid the holdover value keeps driving
                if (any_valid) begin
                    state_next = `ST_LOCKED;
                    switch_now = 1'b1;
                end
            end
            default: state_next = `ST_FREERUN;
        endcase
    end

    // divider of the selected reference feeding the loop
    reg [7:0] div_cnt;
    reg [15:0] meas_cnt;
    reg [15:0] avg_q;
    reg [27:0] avg_timer;
    reg acquired;
    reg [1:0] pbo_cnt;
    wire div_hit = sel_edge && (div_cnt >= div_q);
    wire [16:0] avg_diff = {1'b0, loop_period_reg} - {1'b0, avg_q};
    // long gaps wrap the build-out term; only 24 bits are kept
    wire [31:0] pbo_prod = meas_cnt * `STEPS_PER_CYCLE;
    wire [23:0] pbo_steps = pbo_prod[23:0];
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            loop_state_reg <= `ST_FREERUN;
            sel_ref_reg <= 3'h0;
            div_cnt <= 8'h00;
            meas_cnt <= 16'h0000;
            loop_tick_reg <= 1'b0;
            loop_period_reg <= 16'h0000;
            avg_q <= 16'h0000;
            holdover_reg <= 16'h0000;
            avg_timer <= 28'h0000000;
            acquired <= 1'b0;
            loop_bw_reg <= `BW_MAX;
            slip_count_reg <= 14'h0000;
            phase_adjust_reg <= 24'h000000;
            pbo_active_reg <= 1'b0;
            pbo_cnt <= 2'h0;
        end else begin
            loop_state_reg <= state_next;
            loop_tick_reg <= div_hit && loop_state_reg == `ST_LOCKED;
            if (meas_cnt != 16'hffff)
                meas_cnt <= meas_cnt + 16'h0001;
            if (switch_now) begin
                sel_ref_reg <= best;
                div_cnt <= 8'h00;
                // absorb the phase step of the new input
                phase_adjust_reg <= {{7{offset_q[16]}}, offset_q} +
                    pbo_steps;
                pbo_active_reg <= 1'b1;
                pbo_cnt <= PBO_FULL[1:0];
                meas_cnt <= 16'h0000;
            end else begin
                if (pbo_cnt != 2'h0)
                    pbo_cnt <= pbo_cnt - 2'h1;
                else
                    pbo_active_reg <= 1'b0;
                if (sel_edge)
                    div_cnt <= div_hit ? 8'h00 : div_cnt + 8'h01;
                if (div_hit) begin
                    loop_period_reg <= meas_cnt;
                    meas_cnt <= 16'h0001;
                end
            end
            // running average, latched once per interval while locked
            if (loop_state_reg == `ST_LOCKED) begin
                if (loop_tick_reg)
                    avg_q <= avg_q + {{3{avg_diff[16]}}, avg_diff[15:3]};
                if (avg_timer == AVG_LAST) begin
                    avg_timer <= 28'h0000000;
                    holdover_reg <= avg_q;
                    acquired <= 1'b1;
                end else begin
                    avg_timer <= avg_timer + 28'h0000001;
                end
            end else begin
                avg_timer <= 28'h0000000;
                acquired <= 1'b0;
            end
            loop_bw_reg <= acquired ? bw_lock_q : bw_acq_q;
            // multicycle mode counts cycle slips up to its limit
            if (pd_mode_reg != `PD_MULTI || loop_state_reg != `ST_LOCKED)
                slip_count_reg <= 14'h0000;
            else if (loop_tick_reg && loop_period_reg > holdover_reg &&
                slip_count_reg != `MULTI_LIMIT)
                slip_count_reg <= slip_count_reg + 14'h0001;
        end
    end

    // monitor loop: period of one input or edge distance of two
    reg [15:0] mon_cnt;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_cnt <= 16'h0000;
            mon_result_reg <= 16'h0000;
        end else if (!mon_phase_q) begin
            mon_result_reg <= period[mon_a_q];
        end else begin
            if (ref_edge[mon_a_q])
                mon_cnt <= 16'h0000;
            else if (mon_cnt != 16'hffff)
                mon_cnt <= mon_cnt + 16'h0001;
            if (ref_edge[mon_b_q])
                mon_result_reg <= mon_cnt;
        end
    end

    // master clock enable: oscillator rate times 16 from ref_clk
    reg osc_prev;
    reg [7:0] osc_gap;
    reg [15:0] nco;
    reg master_en;
    wire [16:0] nco_sum = {1'b0, nco} + {1'b0, `MASTER_STEP};
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev <= 1'b0;
            osc_gap <= 8'h00;
            osc_ok_reg <= 1'b0;
            nco <= 16'h0000;
            master_en <= 1'b0;
        end else begin
            osc_prev <= local_oscillator_input;
            if (local_oscillator_input && !osc_prev)
                osc_gap <= 8'h00;
            else if (osc_gap != 8'hff)
                osc_gap <= osc_gap + 8'h01;
            osc_ok_reg <= osc_gap < `OSC_TIMEOUT;
            nco <= nco_sum[15:0];
            master_en <= nco_sum[16] && osc_ok_reg;
        end
    end

    // frame and multiframe sync generation, optionally disciplined
    reg sync_prev;
    reg [14:0] frame_cnt;
    reg [1:0] mframe_cnt;
    reg [7:0] fs_width_cnt;
    reg [7:0] mfs_width_cnt;
    wire sync_edge = sync_in && !sync_prev;
    wire frame_wrap = master_en && frame_cnt == `FRAME_TICKS - 15'h0001;
    wire realign = sync_edge && (sync_mode_q == `SYNC_8K ||
        (sync_mode_q == `SYNC_2K && mframe_cnt == `MFRAME_DIV));
    wire frame_start = frame_wrap || (sync_edge && sync_mode_q == `SYNC_8K);
    wire mframe_start = realign ? (sync_mode_q == `SYNC_2K) :
        (frame_wrap && mframe_cnt == `MFRAME_DIV);
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev <= 1'b0;
            frame_cnt <= 15'h0000;
            mframe_cnt <= 2'h0;
            fs_width_cnt <= 8'h00;
            mfs_width_cnt <= 8'h00;
            fsync_out_reg <= 1'b0;
            mfsync_out_reg <= 1'b0;
        end else begin
            sync_prev <= sync_in;
            if (realign) begin
                frame_cnt <= 15'h0000;
                if (sync_mode_q == `SYNC_2K)
                    mframe_cnt <= 2'h0;
            end else if (frame_wrap) begin
                frame_cnt <= 15'h0000;
                mframe_cnt <= mframe_cnt + 2'h1;
            end else if (master_en) begin
                frame_cnt <= frame_cnt + 15'h0001;
            end
            // width counted in ref_clk cycles, zero means one cycle
            if (frame_start || realign)
                fs_width_cnt <= fsync_width_q;
            else if (fs_width_cnt != 8'h00)
                fs_width_cnt <= fs_width_cnt - 8'h01;
            if (mframe_start)
                mfs_width_cnt <= fsync_width_q;
            else if (mfs_width_cnt != 8'h00)
                mfs_width_cnt <= mfs_width_cnt - 8'h01;
            fsync_out_reg <= fsync_pol_q ^ (frame_start || realign ||
                fs_width_cnt != 8'h00);
            mfsync_out_reg <= fsync_pol_q ^ (mframe_start ||
                mfs_width_cnt != 8'h00);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/ref_select_map.vh ====
// constants for the reference select and main loop control core
// assumes ref_clk at 250 MHz, 4 ns period
`ifndef REF_SELECT_MAP_VH
`define REF_SELECT_MAP_VH
`define NUM_IN 5
`define ST_FREERUN 3'h1
`define ST_LOCKED 3'h2
`define ST_HOLDOVER 3'h4
`define CLK_MHZ 250
`define CLK_PERIOD_PS 4000
// loop bandwidth limits in Hz
`define BW_MIN 9'h012
`define BW_MAX 9'h190
`define MON_BW_MAX 9'h046
// damping codes 1.2, 2.5, 5, 10, 20
`define DAMP_MAX 3'h4
`define PD_PFD 2'h0
`define PD_NEAREST 2'h1
`define PD_MULTI 2'h2
`define MULTI_LIMIT 14'h1fff
// phase offset and build-out timing
`define PHASE_STEP_PS 6
`define STEPS_PER_CYCLE (`CLK_PERIOD_PS / `PHASE_STEP_PS)
`define PBO_LIMIT_NS 5
`define PBO_CYCLES ((`PBO_LIMIT_NS * 1000) / `CLK_PERIOD_PS)
// holdover averaging interval
`define AVG_TIME_MS 1000
`define AVG_CYCLES (`AVG_TIME_MS * `CLK_MHZ * 1000)
// master clock: oscillator times 16, as an enable from ref_clk
`define OSC_MULT 16
`define OSC_KHZ 12800
`define MASTER_STEP 16'hd1b7
`define OSC_TIMEOUT 8'h28
// frame sync: 8 kHz from 204.8 MHz, multiframe every 4th frame
`define FRAME_TICKS 15'h6400
`define MFRAME_DIV 2'h3
`define SYNC_NONE 2'h0
`define SYNC_8K 2'h1
`define SYNC_2K 2'h2
`endif

// ==== verification/reference_select_dpll_control_assertions.sv ====
// checker for the reference select and main loop control core
// assumes one 250 MHz domain; bound onto the core's ports below
`timescale 1ns/1ns
`default_nettype none
`include "ref_select_map.vh"
module dpll_ctl_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [4:0] ref_in,
    input wire logic write_protect,
    input wire logic [2:0] loop_state_reg,
    input wire logic [2:0] sel_ref_reg,
    input wire logic [4:0] ref_valid_reg,
    input wire logic loop_tick_reg,
    input wire logic [15:0] holdover_reg,
    input wire logic [8:0] loop_bw_reg,
    input wire logic [2:0] damping_reg,
    input wire logic [1:0] pd_mode_reg,
    input wire logic [8:0] mon_bw_reg,
    input wire logic pbo_active_reg
);
    // single domain, so clock and reset are named once
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_state_one_hot: assert property ($onehot(loop_state_reg))
        else $error("loop state not one-hot");
    a_lock_needs_valid: assert property (
        $rose(loop_state_reg[1]) |-> $past(ref_valid_reg) != 5'h00)
        else $error("locked without a valid input");
    a_switch_runs_pbo: assert property (
        $changed(sel_ref_reg) |-> pbo_active_reg
            && loop_state_reg == `ST_LOCKED)
        else $error("switch without build-out");
    a_pbo_two_cycles: assert property (
        $rose(pbo_active_reg) |-> pbo_active_reg [*2] ##1 !pbo_active_reg)
        else $error("build-out pulse width wrong");
    a_all_lost_hold: assert property (
        loop_state_reg == `ST_HOLDOVER && ref_valid_reg == 5'h00
            |=> loop_state_reg == `ST_HOLDOVER)
        else $error("left holdover with no input");
    a_tick_not_freerun: assert property (
        loop_tick_reg |-> loop_state_reg != `ST_FREERUN)
        else $error("loop tick in free-run");
    a_holdover_frozen: assert property (
        $past(loop_state_reg) != `ST_LOCKED |-> $stable(holdover_reg))
        else $error("holdover value moved outside lock");
    a_clamp_codes: assert property (
        damping_reg <= `DAMP_MAX && pd_mode_reg != 2'h3)
        else $error("damping or detector code out of range");
    a_bw_ranges: assert property (
        loop_bw_reg >= `BW_MIN && loop_bw_reg <= `BW_MAX
            && mon_bw_reg <= `MON_BW_MAX)
        else $error("bandwidth out of range");
    a_protect_holds: assert property (
        write_protect && $past(write_protect) && $past(write_protect, 2)
            |-> $stable(damping_reg) && $stable(pd_mode_reg))
        else $error("config changed while protected");
    a_valid_after_edge: assert property (
        $rose(ref_valid_reg[0]) |-> $past(ref_in[0]) || $past(ref_in[0], 2))
        else $error("input valid without an edge");
endmodule
bind reference_select_dpll_control dpll_ctl_checker dpll_ctl_checker_i (
    .ref_clk, .rst_n, .ref_in, .write_protect, .loop_state_reg,
    .sel_ref_reg, .ref_valid_reg, .loop_tick_reg, .holdover_reg,
    .loop_bw_reg, .damping_reg, .pd_mode_reg, .mon_bw_reg, .pbo_active_reg
);
`default_nettype wire

// ==== verification/ref_source.sv ====
// reference sources standing in for the redundant timing cards
// assumes 1 ns steps; edges stay off the 4 ns sampling grid
`timescale 1ns/1ns
`default_nettype none
module ref_source (
    input wire logic [4:0] run,
    input wire logic [39:0] half_ns,
    output wire logic [4:0] ref_out,
    output logic osc_out
);
    // each card toggles on its own timer and sits low once it fails
    for (genvar i = 0; i < 5; i++) begin : g_card
        logic q = 1'b0;
        assign ref_out[i] = q;
        initial begin
            #1;
            forever begin
                if (run[i]) begin
                    #(half_ns[8*i +: 8]) q = ~q;
                end else begin
                    q = 1'b0;
                    #4;
                end
            end
        end
    end
    // 12.5 MHz stands in for the oscillator so its edges keep the grid
    initial begin
        osc_out = 1'b0;
        #1;
        forever #40 osc_out = ~osc_out;
    end
endmodule
`default_nettype wire

// ==== verification/reference_select_dpll_control_tb.sv ====
// self-checking bench for the reference select and main loop core
// assumes the core's map header and the reference source model
`timescale 1ns/1ns
`default_nettype none
`include "ref_select_map.vh"
module reference_select_dpll_control_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_load = 1'b0;
    logic write_protect = 1'b0;
    logic revertive_in = 1'b1;
    logic [2:0] damping_in = 3'h0;
    logic [1:0] pd_mode_in = 2'h0;
    logic [8:0] mon_bw_in = 9'h046;
    // more config driven from the bench; divider, period window, offset and sync width are tied at the instance
    logic sync_in = 1'b0;
    logic [14:0] prio_table_in = 15'h00ca;
    logic [8:0] bw_acq_in = 9'h005;
    logic [8:0] bw_lock_in = 9'h1ff;
    logic [2:0] mon_sel_a_in = 3'h0;
    logic [2:0] mon_sel_b_in = 3'h1;
    logic mon_phase_mode_in = 1'b0;
    logic fsync_pol_in = 1'b1;
    logic [1:0] sync_mode_in = `SYNC_NONE;
    logic [4:0] run = 5'h00;
    // card 2 at half rate, outside the 8..12 cycle window
    logic [39:0] half_ns = 40'h14_14_28_14_14;
    wire logic [4:0] ref_in;
    wire logic local_oscillator_input;
    wire logic [2:0] loop_state_reg, sel_ref_reg, damping_reg;
    wire logic [4:0] ref_valid_reg;
    wire logic [15:0] loop_period_reg, holdover_reg, mon_result_reg;
    wire logic [8:0] loop_bw_reg, mon_bw_reg;
    wire logic [1:0] pd_mode_reg;
    wire logic osc_ok_reg, fsync_out_reg, mfsync_out_reg;
    int err_count = 0;
    int tests_run = 0;

    // card1 best, card0 next, card2 last; short averaging interval
    reference_select_dpll_control #(.AVG_CYCLES(200))
        reference_select_dpll_control_i (
        .ref_clk, .rst_n, .local_oscillator_input, .ref_in,
        .sync_in, .cfg_load, .write_protect,
        .prio_table_in, .revertive_in, .div_ratio_in(8'h01),
        .period_lo_in(16'h0008), .period_hi_in(16'h000c),
        .bw_acq_in, .bw_lock_in, .damping_in, .pd_mode_in,
        .phase_offset_in(17'h00064), .mon_sel_a_in,
        .mon_sel_b_in, .mon_phase_mode_in, .mon_bw_in,
        .fsync_pol_in, .fsync_width_in(8'h03),
        .sync_mode_in, .loop_state_reg, .sel_ref_reg,
        .ref_valid_reg, .loop_tick_reg(), .loop_period_reg, .holdover_reg,
        .loop_bw_reg, .damping_reg, .pd_mode_reg, .slip_count_reg(),
        .phase_adjust_reg(), .pbo_active_reg(), .mon_result_reg,
        .mon_bw_reg, .osc_ok_reg, .fsync_out_reg, .mfsync_out_reg
    );
    ref_source ref_source_i (
        .run, .half_ns, .ref_out(ref_in), .osc_out(local_oscillator_input)
    );

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %0h expected %0h",
                $time, got, exp);
        end
    endtask

    // config load; outputs settle within one edge after it is taken
    task automatic load(input logic [2:0] d, input logic [1:0] p,
        input logic [8:0] mb, input logic rv, input logic wp);
        @(posedge ref_clk);
        damping_in <= d;
        pd_mode_in <= p;
        mon_bw_in <= mb;
        revertive_in <= rv;
        write_protect <= wp;
        cfg_load <= 1'b1;
        @(posedge ref_clk);
        cfg_load <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // bounded wait; a timeout shows up as a mismatch
    task automatic wait_state(input logic [2:0] s, input int lim);
        int n;
        n = 0;
        #1;
        while (loop_state_reg !== s && n < lim) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(loop_state_reg, s);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk(loop_state_reg, `ST_FREERUN);
        chk(loop_bw_reg, `BW_MAX);
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            load(k[2:0], k[1:0], 9'h043 + k[8:0], 1'b1, 1'b0);
            chk(damping_reg, (k > 4) ? 3'h0 : k[2:0]);
            chk(pd_mode_reg, (k[1:0] == 2'h3) ? 2'h0 : k[1:0]);
            chk(mon_bw_reg, (k > 3) ? `MON_BW_MAX : 9'h043 + k[8:0]);
        end
        chk(loop_bw_reg, `BW_MIN);
        chk({fsync_out_reg, mfsync_out_reg}, 2'h3);
        load(3'h2, 2'h1, 9'h020, 1'b1, 1'b1);
        chk(damping_reg, 3'h0);
        chk(pd_mode_reg, 2'h0);
        @(posedge ref_clk);
        sync_mode_in <= `SYNC_8K;
        load(3'h1, `PD_MULTI, 9'h030, 1'b1, 1'b0);
        chk(damping_reg, 3'h1);
        // a sync edge restarts the frame: width 3 gives 4 active cycles
        @(posedge ref_clk);
        sync_in <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk({fsync_out_reg, mfsync_out_reg}, 2'h1);
        repeat (3) @(posedge ref_clk);
        #1;
        chk({fsync_out_reg, mfsync_out_reg}, 2'h1);
        @(posedge ref_clk);
        sync_in <= 1'b0;
        #1;
        chk({fsync_out_reg, mfsync_out_reg}, 2'h3);
        $display("test config done");
        @(posedge ref_clk);
        run <= 5'h05;
        wait_state(`ST_LOCKED, 100);
        chk(sel_ref_reg, 3'h0);
        repeat (300) @(posedge ref_clk);
        #1;
        chk(ref_valid_reg, 5'h01);
        chk(loop_period_reg, 16'h0014);
        chk(mon_result_reg, 16'h000a);
        chk(loop_bw_reg, `BW_MAX);
        chk(holdover_reg != 16'h0000, 1'b1);
        chk(osc_ok_reg, 1'b1);
        $display("test lock done");
        @(posedge ref_clk);
        run <= 5'h07;
        repeat (100) @(posedge ref_clk);
        #1;
        chk(sel_ref_reg, 3'h1);
        @(posedge ref_clk);
        run <= 5'h05;
        wait_state(`ST_HOLDOVER, 30);
        wait_state(`ST_LOCKED, 10);
        chk(sel_ref_reg, 3'h0);
        $display("test switch done");
        load(3'h1, `PD_MULTI, 9'h030, 1'b0, 1'b0);
        @(posedge ref_clk);
        run <= 5'h07;
        repeat (100) @(posedge ref_clk);
        #1;
        chk(sel_ref_reg, 3'h0);
        @(posedge ref_clk);
        run <= 5'h00;
        wait_state(`ST_HOLDOVER, 40);
        repeat (200) @(posedge ref_clk);
        #1;
        chk(loop_state_reg, `ST_HOLDOVER);
        chk(ref_valid_reg, 5'h00);
        $display("test holdover done");
        report_and_stop();
    end

    // watchdog, well past the expected run of under a thousand cycles
    initial begin
        #20000;
        err_count++;
        $display("watchdog expired at %0t", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
